// [rtl/can_mailbox_defines.vh]
// constants for the mailbox layer: register offsets, field positions, reset values
// assumes a 12-bit byte address on the register bus and 32-bit data
`ifndef CAN_MAILBOX_DEFINES_VH
`define CAN_MAILBOX_DEFINES_VH

// register offsets (byte addresses)
`define OFS_MASTER_CTRL 12'h000
`define OFS_MBOX_ENABLE 12'h004
`define OFS_DIRECTION 12'h008
`define OFS_TX_REQ_SET 12'h00C
`define OFS_RX_PENDING 12'h010
`define OFS_RX_LOST 12'h014
`define OFS_OVR_PROTECT 12'h018
`define OFS_STATUS 12'h01C
// memory windows: base byte address of each window
`define OFS_MASK_BASE 12'h100
`define OFS_MBOX_BASE 12'h200
`define OFS_AUX_BASE 12'h400

// master control fields
`define MC_COMPAT_BIT 0
`define MC_LOOPBACK_BIT 1
`define MC_RESET 32'h0000_0001

// identifier word fields
`define ID_IDE_BIT 31
`define ID_MASK_EN_BIT 30
`define ID_AUTO_ANS_BIT 29
`define STD_ID_CARE 29'h1FFC_0000

// control word fields
`define CTL_RTR_BIT 4
`define CTL_LEVEL_LSB 8

// mailbox types
`define MB_TRANSMIT 2'h0
`define MB_RECEIVE 2'h1
`define MB_REQUEST 2'h2
`define MB_REPLY 2'h3

// counts
`define NUM_MBOX 32
`define BASIC_MBOX 16

`endif

// [rtl/can_message_mailboxes.v]
// message object and mailbox layer of a can message controller: apb slave, mailbox ram,
// acceptance filtering, and transmit priority selection toward the protocol kernel
// assumes kernel strobes are one-cycle pulses synchronous to core_clk_in
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "can_mailbox_defines.vh"

module can_message_mailboxes #(
   parameter LEVEL_W = 5
) (
   // clock, reset, enable
   input wire core_clk_in,
   input wire resetn_in,
   input wire ce_in,
   // apb slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [3:0] pstrb_in,
   output wire [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   // transmit side of the protocol kernel
   output wire tx_valid_out,
   output wire [4:0] tx_mbox_out,
   output wire tx_ide_out,
   output wire [28:0] tx_id_out,
   output wire tx_rtr_out,
   output wire [3:0] tx_dlc_out,
   output wire [63:0] tx_data_out,
   input wire tx_done_in,
   input wire tx_fail_in,
   // receive side of the protocol kernel
   input wire rx_valid_in,
   input wire rx_ide_in,
   input wire [28:0] rx_id_in,
   input wire rx_rtr_in,
   input wire [3:0] rx_dlc_in,
   input wire [63:0] rx_data_in,
   // event strobes
   output wire rx_stored_out,
   output wire [4:0] rx_mbox_out,
   output wire tx_sent_out
);

localparam ST_IDLE = 1'b0;
localparam ST_BUSY = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// helpers

// decodes the object type from its three configuration bits
function [1:0] mbox_type;
   input md;
   input auto_ans;
   input rtr;
   begin
      if (auto_ans && !md && !rtr) mbox_type = `MB_REPLY;
      else if (md && rtr) mbox_type = `MB_REQUEST;
      else if (md) mbox_type = `MB_RECEIVE;
      else mbox_type = `MB_TRANSMIT;
   end
endfunction

// which mask word applies: shared groups in basic mode, private otherwise
function [4:0] mask_idx;
   input compat;
   input [4:0] mb;
   begin
      if (!compat) mask_idx = mb;
      else if (mb < 5'd3) mask_idx = 5'd0;
      else if (mb < 5'd6) mask_idx = 5'd3;
      else mask_idx = 5'd6;
   end
endfunction

// merges apb write data into a ram word under the byte strobes
function [31:0] merge;
   input [31:0] old;
   input [31:0] nw;
   input [3:0] strb;
   integer b;
   begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
         if (strb[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// reset release through two flops
reg [1:0] rst_sync_q;
wire rst_n;

always @(posedge core_clk_in or negedge resetn_in) begin
   if (!resetn_in) rst_sync_q <= 2'b00;
   else rst_sync_q <= {rst_sync_q[0], 1'b1};
end
assign rst_n = rst_sync_q[1];

////////////////////////////////////////////////////////////////////////////////
// state
reg [31:0] mc_q;
reg [31:0] me_q;
reg [31:0] md_q;
reg [31:0] tx_req_q;
reg [31:0] rx_pend_q;
reg [31:0] rx_lost_q;
reg [31:0] ovr_prot_q;
reg [4:0] last_rx_q;
reg [31:0] prdata_q;
reg pready_q;
reg pslverr_q;
reg state_q;
reg [4:0] tx_mbox_q;
reg tx_ide_q;
reg [28:0] tx_id_q;
reg tx_rtr_q;
reg [3:0] tx_dlc_q;
reg [63:0] tx_data_q;
reg rx_stored_q;
reg [4:0] rx_mbox_q;
reg tx_sent_q;

// memories: four words per mailbox, one mask per mailbox, stamp and time-out words
reg [31:0] mbox_ram [0:127];
reg [31:0] mask_ram [0:31];
reg [31:0] aux_ram [0:63];

wire compat = mc_q[`MC_COMPAT_BIT];
wire loop = mc_q[`MC_LOOPBACK_BIT];

////////////////////////////////////////////////////////////////////////////////
// apb decode
wire acc = psel_in & penable_in & ~pready_q;
wire wr_en = ce_in & psel_in & penable_in & pready_q & pwrite_in;
wire in_reg = (paddr_in[11:5] == 7'h00);
wire [11:0] mask_base = `OFS_MASK_BASE;
wire [11:0] mbox_base = `OFS_MBOX_BASE;
wire [11:0] aux_base = `OFS_AUX_BASE;
wire in_mask = (paddr_in[11:7] == mask_base[11:7]);
wire in_mbox = (paddr_in[11:9] == mbox_base[11:9]);
wire in_aux = (paddr_in[11:8] == aux_base[11:8]);
wire reg_wr = wr_en & in_reg;
wire [11:0] reg_ofs = {7'h00, paddr_in[4:0]};

reg [31:0] rd_data;
reg rd_err;

// read mux; the register area answers whole words only
always @* begin
   rd_data = 32'h0000_0000;
   rd_err = 1'b0;
   if (in_mbox) rd_data = mbox_ram[paddr_in[8:2]];
   else if (in_mask) rd_data = mask_ram[paddr_in[6:2]];
   else if (in_aux) rd_data = aux_ram[paddr_in[7:2]];
   else if (in_reg) begin
      case (reg_ofs)
         `OFS_MASTER_CTRL: rd_data = mc_q;
         `OFS_MBOX_ENABLE: rd_data = me_q;
         `OFS_DIRECTION: rd_data = md_q;
         `OFS_TX_REQ_SET: rd_data = tx_req_q;
         `OFS_RX_PENDING: rd_data = rx_pend_q;
         `OFS_RX_LOST: rd_data = rx_lost_q;
         `OFS_OVR_PROTECT: rd_data = ovr_prot_q;
         `OFS_STATUS: rd_data = {18'h00000, state_q, tx_mbox_q, 3'h0, last_rx_q};
         default: rd_err = 1'b1;
      endcase
   end else rd_err = 1'b1;
end

// one wait state: answer is registered so the bus outputs come from flops
always @(posedge core_clk_in or negedge rst_n) begin
   if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
   end else if (ce_in) begin
      pready_q <= acc;
      pslverr_q <= acc & rd_err;
      prdata_q <= (acc & ~pwrite_in) ? rd_data : 32'h0000_0000;
   end
end

////////////////////////////////////////////////////////////////////////////////
// receive filtering: combinational search from the top mailbox down
reg rx_hit;
reg [4:0] rx_sel;
reg [31:0] lost_set;
reg any_rx_cfg;
reg [31:0] idw;
reg [28:0] care;
reg capable;
integer i;

always @* begin
   rx_hit = 1'b0;
   rx_sel = 5'h00;
   lost_set = 32'h0000_0000;
   any_rx_cfg = 1'b0;
   idw = 32'h0000_0000;
   care = 29'h0000_0000;
   capable = 1'b0;
   for (i = 31; i >= 0; i = i - 1) begin
      idw = mbox_ram[i*4];
      capable = me_q[i] & (~compat | (i < `BASIC_MBOX))
         & (mbox_type(md_q[i], idw[`ID_AUTO_ANS_BIT], mbox_ram[i*4+1][`CTL_RTR_BIT]) == `MB_RECEIVE
         | mbox_type(md_q[i], idw[`ID_AUTO_ANS_BIT], mbox_ram[i*4+1][`CTL_RTR_BIT]) == `MB_REQUEST);
      if (capable) any_rx_cfg = 1'b1;
      if (loop && i == 0) capable = 1'b1;
      care = rx_ide_in ? 29'h1FFF_FFFF : `STD_ID_CARE;
      if (idw[`ID_MASK_EN_BIT]) care = care & ~mask_ram[mask_idx(compat, i[4:0])][28:0];
      if (!rx_hit && capable && idw[`ID_IDE_BIT] == rx_ide_in
          && ((idw[28:0] ^ rx_id_in) & care) == 29'h0000_0000) begin
         if (rx_pend_q[i]) lost_set[i] = 1'b1;
         if (!(rx_pend_q[i] && ovr_prot_q[i])) begin
            rx_hit = 1'b1;
            rx_sel = i[4:0];
         end
      end
   end
   if (loop && !any_rx_cfg) begin
      rx_hit = 1'b1;
      rx_sel = last_rx_q;
   end
end

wire rx_store = ce_in & rx_valid_in & rx_hit;

////////////////////////////////////////////////////////////////////////////////
// transmit selection: highest level, ties go to the higher number
reg tx_hit;
reg [4:0] tx_sel;
reg [LEVEL_W-1:0] best;
reg [LEVEL_W-1:0] lvl;
integer j;

always @* begin
   tx_hit = 1'b0;
   tx_sel = 5'h00;
   best = {LEVEL_W{1'b0}};
   lvl = {LEVEL_W{1'b0}};
   for (j = 0; j < 32; j = j + 1) begin
      // basic mode ignores the level so number alone decides
      lvl = compat ? {LEVEL_W{1'b0}} : mbox_ram[j*4+1][`CTL_LEVEL_LSB +: LEVEL_W];
      if (me_q[j] && tx_req_q[j] && (!compat || j < `BASIC_MBOX) && (!tx_hit || lvl >= best)) begin
         tx_hit = 1'b1;
         tx_sel = j[4:0];
         best = lvl;
      end
   end
end

wire tx_start = ce_in & (state_q == ST_IDLE) & tx_hit;
wire tx_ok = ce_in & (state_q == ST_BUSY) & tx_done_in;

// transmit sequencer toward the kernel
always @(posedge core_clk_in or negedge rst_n) begin
   if (!rst_n) begin
      state_q <= ST_IDLE;
      tx_mbox_q <= 5'h00;
      tx_ide_q <= 1'b0;
      tx_id_q <= 29'h0000_0000;
      tx_rtr_q <= 1'b0;
      tx_dlc_q <= 4'h0;
      tx_data_q <= 64'h0000_0000_0000_0000;
      tx_sent_q <= 1'b0;
   end else if (ce_in) begin
      tx_sent_q <= tx_ok;
      case (state_q)
         ST_IDLE: begin
            if (tx_start) begin
               state_q <= ST_BUSY;
               tx_mbox_q <= tx_sel;
               tx_ide_q <= mbox_ram[{tx_sel, 2'b00}][`ID_IDE_BIT];
               tx_id_q <= mbox_ram[{tx_sel, 2'b00}][28:0];
               tx_rtr_q <= mbox_ram[{tx_sel, 2'b01}][`CTL_RTR_BIT];
               tx_dlc_q <= mbox_ram[{tx_sel, 2'b01}][3:0];
               tx_data_q <= {mbox_ram[{tx_sel, 2'b10}], mbox_ram[{tx_sel, 2'b11}]};
            end
         end
         ST_BUSY: begin
            // a failed attempt drops back so the next pick sees every request again
            if (tx_done_in || tx_fail_in) state_q <= ST_IDLE;
         end
         default: state_q <= ST_IDLE;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// control and flag registers; hardware set wins over a cpu clear
wire [31:0] tx_clr = tx_ok ? (32'h0000_0001 << tx_mbox_q) : 32'h0000_0000;
wire [31:0] rx_set = rx_store ? (32'h0000_0001 << rx_sel) : 32'h0000_0000;
wire [31:0] lost_hw = (ce_in & rx_valid_in) ? lost_set : 32'h0000_0000;
wire [31:0] tx_req_wr = (reg_wr && reg_ofs == `OFS_TX_REQ_SET) ? pwdata_in : 32'h0000_0000;
wire [31:0] rx_pend_wr = (reg_wr && reg_ofs == `OFS_RX_PENDING) ? pwdata_in : 32'h0000_0000;
wire [31:0] rx_lost_wr = (reg_wr && reg_ofs == `OFS_RX_LOST) ? pwdata_in : 32'h0000_0000;

always @(posedge core_clk_in or negedge rst_n) begin
   if (!rst_n) begin
      mc_q <= `MC_RESET;
      me_q <= 32'h0000_0000;
      md_q <= 32'h0000_0000;
      tx_req_q <= 32'h0000_0000;
      rx_pend_q <= 32'h0000_0000;
      rx_lost_q <= 32'h0000_0000;
      ovr_prot_q <= 32'h0000_0000;
      last_rx_q <= 5'h00;
      rx_stored_q <= 1'b0;
      rx_mbox_q <= 5'h00;
   end else if (ce_in) begin
      if (reg_wr && reg_ofs == `OFS_MASTER_CTRL) mc_q <= {30'h0000_0000, pwdata_in[1:0]};
      if (reg_wr && reg_ofs == `OFS_MBOX_ENABLE) me_q <= pwdata_in;
      if (reg_wr && reg_ofs == `OFS_DIRECTION) md_q <= pwdata_in;
      if (reg_wr && reg_ofs == `OFS_OVR_PROTECT) ovr_prot_q <= pwdata_in;
      tx_req_q <= (tx_req_q & ~tx_clr) | tx_req_wr;
      rx_pend_q <= (rx_pend_q & ~rx_pend_wr) | rx_set;
      rx_lost_q <= (rx_lost_q & ~rx_lost_wr) | lost_hw;
      rx_stored_q <= rx_store;
      if (rx_store) begin
         rx_mbox_q <= rx_sel;
         last_rx_q <= rx_sel;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// memories: cpu writes anywhere, enabled or not; a frame store wins the same word
always @(posedge core_clk_in) begin
   if (wr_en && in_mbox) mbox_ram[paddr_in[8:2]] <= merge(mbox_ram[paddr_in[8:2]], pwdata_in, pstrb_in);
   if (wr_en && in_mask) mask_ram[paddr_in[6:2]] <= merge(mask_ram[paddr_in[6:2]], pwdata_in, pstrb_in);
   if (wr_en && in_aux) aux_ram[paddr_in[7:2]] <= merge(aux_ram[paddr_in[7:2]], pwdata_in, pstrb_in);
   if (rx_store) begin
      mbox_ram[{rx_sel, 2'b00}] <= {rx_ide_in, mbox_ram[{rx_sel, 2'b00}][30:29], rx_id_in};
      mbox_ram[{rx_sel, 2'b01}] <= {mbox_ram[{rx_sel, 2'b01}][31:5], rx_rtr_in, rx_dlc_in};
      mbox_ram[{rx_sel, 2'b10}] <= rx_data_in[63:32];
      mbox_ram[{rx_sel, 2'b11}] <= rx_data_in[31:0];
   end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
assign prdata_out = prdata_q;
assign pready_out = pready_q;
assign pslverr_out = pslverr_q;
assign tx_valid_out = state_q;
assign tx_mbox_out = tx_mbox_q;
assign tx_ide_out = tx_ide_q;
assign tx_id_out = tx_id_q;
assign tx_rtr_out = tx_rtr_q;
assign tx_dlc_out = tx_dlc_q;
assign tx_data_out = tx_data_q;
assign rx_stored_out = rx_stored_q;
assign rx_mbox_out = rx_mbox_q;
assign tx_sent_out = tx_sent_q;

endmodule

// [verification/can_mbox_chk_asserts.sv]
// port checker for the mailbox layer, bound into the design top
// assumes ce_in stays high during every bus access
`timescale 1ns/10ps
module can_mbox_chk (
   // clock and reset
   input wire core_clk_in,
   input wire resetn_in,
   input wire ce_in,
   // apb
   input wire psel_in,
   input wire penable_in,
   input wire pready_out,
   input wire pslverr_out,
   // kernel
   input wire tx_valid_out,
   input wire [4:0] tx_mbox_out,
   input wire tx_done_in,
   input wire tx_fail_in,
   input wire rx_valid_in,
   input wire rx_stored_out,
   input wire tx_sent_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   ////////////////////////////////////////////////////////////////
   // steps of an access and of a frame offer
   sequence s_acc;
      psel_in && penable_in && !pready_out && ce_in;
   endsequence
   sequence s_end;
      tx_valid_out && (tx_done_in || tx_fail_in);
   endsequence
   ////////////////////////////////////////////////////////////////
   // one wait state, then a one-cycle answer
   a_apb_wait: assert property (s_acc |=> pready_out) else $error("ready late");
   a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready too long");
   a_err_ready: assert property (pslverr_out |-> pready_out) else $error("lone error");
   // an offer stands until the kernel answers
   a_tx_hold: assert property (tx_valid_out && !tx_done_in && !tx_fail_in |=>
      tx_valid_out && $stable(tx_mbox_out)) else $error("offer dropped");
   a_tx_drop: assert property (s_end |=> !tx_valid_out) else $error("offer kept");
   a_tx_sent: assert property (tx_valid_out && tx_done_in |=> tx_sent_out) else $error("no sent");
   a_sent_cause: assert property (tx_sent_out |-> $past(tx_valid_out && tx_done_in)) else $error("stray sent");
   // a failed try is never reported as sent, so it stays pending
   a_fail_nosend: assert property (s_end ##0 !tx_done_in |=> !tx_sent_out) else $error("fail sent");
   a_rx_cause: assert property (rx_stored_out |-> $past(rx_valid_in)) else $error("stray store");
endmodule
bind can_message_mailboxes can_mbox_chk chk (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
   .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .tx_valid_out(tx_valid_out), .tx_mbox_out(tx_mbox_out),
   .tx_done_in(tx_done_in), .tx_fail_in(tx_fail_in), .rx_valid_in(rx_valid_in),
   .rx_stored_out(rx_stored_out), .tx_sent_out(tx_sent_out));

// [verification/can_kernel_model.sv]
// behavioural protocol kernel: answers frame offers and delivers received frames
// assumes one clock shared with the mailbox layer
`timescale 1ns/10ps
module can_kernel_model (
   // clock and reset
   input wire clk_in,
   input wire resetn_in,
   // control from the bench
   input wire [3:0] lat_in,
   input wire fail_in,
   // transmit side
   input wire tx_valid_in,
   output logic tx_done_out,
   output logic tx_fail_out,
   // receive side
   output logic rx_valid_out = 1'h0,
   output logic rx_ide_out = 1'h0,
   output logic [28:0] rx_id_out = 29'h0,
   output logic rx_rtr_out = 1'h0,
   output logic [3:0] rx_dlc_out = 4'h0,
   output logic [63:0] rx_data_out = 64'h0
);
   logic [3:0] cnt;
   ////////////////////////////////////////////////////////////////
   // answer after lat_in cycles; a pulse is never repeated on one offer
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_done_out <= 1'h0;
         tx_fail_out <= 1'h0;
         cnt <= 4'h0;
      end else if (tx_done_out || tx_fail_out) begin
         tx_done_out <= 1'h0;
         tx_fail_out <= 1'h0;
         cnt <= 4'h0;
      end else if (tx_valid_in && cnt == lat_in) begin
         tx_fail_out <= fail_in; // lost arbitration on command
         tx_done_out <= !fail_in;
      end else if (tx_valid_in) begin
         cnt <= cnt + 4'h1;
      end
   end
   // one frame for one cycle; id and data lines then show the inverse, not stale data
   task send(input logic ide, input logic [28:0] id, input logic [63:0] d);
      @(posedge clk_in);
      rx_valid_out <= 1'h1;
      rx_ide_out <= ide;
      rx_id_out <= id;
      rx_dlc_out <= 4'h8;
      rx_data_out <= d;
      @(posedge clk_in);
      rx_valid_out <= 1'h0;
      rx_id_out <= ~id;
      rx_data_out <= ~d;
   endtask
endmodule

// [verification/can_message_mailboxes_tb_top.sv]
// self-checking bench for the mailbox layer
// assumes the kernel model beside the design and the checker bound inside it
`timescale 1ns/10ps
`include "can_mailbox_defines.vh"
module can_message_mailboxes_tb_top;
   logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, fail = 1'h0;
   logic [11:0] pa = 12'h0;
   logic [31:0] pwd = 32'h0, prd, r;
   logic [3:0] pst = 4'hF, lat = 4'h0, dlc, rdlc;
   logic pready, perr, e, txv, ide, rtr, done, txf, rxv, ride, rrtr, stored, sent;
   logic [4:0] txmb, rxmb, last_rx, fail_mb;
   logic ce = 1'h1;
   logic [28:0] txid, rid, cap_id;
   logic [63:0] txd, rd_data, cap_d;
   logic [5:0] cap_c;
   int bad_count = 0, cmp_count = 0, cyc = 0, rx_cnt = 0, sent_cnt = 0, i;
   logic [4:0] sent_q[$];
   logic [43:0] rows [6] = '{{`OFS_MBOX_BASE, 32'h9ABC_DEF0}, {12'h3F8, 32'h0F0F_A5A5},
      {`OFS_MASK_BASE, 32'h1FFF_FFFF}, {12'h47C, 32'hCAFE_0001}, {12'h4FC, 32'h0000_BEEF},
      {`OFS_OVR_PROTECT, 32'h0000_00FF}};
   always #4 clk = ~clk;
   can_message_mailboxes dut (.core_clk_in(clk), .resetn_in(rstn), .ce_in(ce), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(pst),
      .prdata_out(prd), .pready_out(pready), .pslverr_out(perr), .tx_valid_out(txv),
      .tx_mbox_out(txmb), .tx_ide_out(ide), .tx_id_out(txid), .tx_rtr_out(rtr), .tx_dlc_out(dlc),
      .tx_data_out(txd), .tx_done_in(done), .tx_fail_in(txf), .rx_valid_in(rxv), .rx_ide_in(ride),
      .rx_id_in(rid), .rx_rtr_in(rrtr), .rx_dlc_in(rdlc), .rx_data_in(rd_data),
      .rx_stored_out(stored), .rx_mbox_out(rxmb), .tx_sent_out(sent));
   can_kernel_model kern (.clk_in(clk), .resetn_in(rstn), .lat_in(lat), .fail_in(fail),
      .tx_valid_in(txv), .tx_done_out(done), .tx_fail_out(txf), .rx_valid_out(rxv),
      .rx_ide_out(ride), .rx_id_out(rid), .rx_rtr_out(rrtr), .rx_dlc_out(rdlc), .rx_data_out(rd_data));
   ////////////////////////////////////////////////////////////////
   // monitor of stores and sends, plus the hang limit
   always @(posedge clk) begin
      cyc++;
      if (stored) begin
         last_rx <= rxmb;
         rx_cnt++;
      end
      if (sent) sent_cnt++;
      if (txv && done) begin
         sent_q.push_back(txmb);
         cap_id <= txid;
         cap_d <= txd;
         cap_c <= {ide, rtr, dlc};
      end
      if (txv && txf) fail_mb <= txmb;
      if (cyc == 20000) begin
         bad_count++;
         complete_run;
      end
   end
   task complete_run;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // apb master: held until pready seen at a rising edge
   task apb(input logic [11:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pa <= a;
      pwd <= d;
      pwr <= w;
      pst <= s;
      @(posedge clk);
      pen <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) bad_count++;
      r = prd;
      e = perr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      apb(a, d, 1'h1, s);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(a, 32'h0, 1'h0, 4'hF);
      chk(r, x);
   endtask
   task wq(input int n);
      for (i = 0; sent_q.size() < n && i < 500; i++) @(posedge clk);
      if (i >= 500) bad_count++;
   endtask
   task frame(input logic [28:0] id, input logic [63:0] d);
      kern.send(1'h1, id, d);
      repeat (2) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      rd(`OFS_MASTER_CTRL, `MC_RESET);
      rd(`OFS_MBOX_ENABLE, 32'h0);
      apb(12'h020, 32'h0, 1'h0, 4'hF);
      chk(e, 32'h1);
      // memory and register rows: write, then read back
      foreach (rows[k]) begin
         wr(rows[k][43:32], rows[k][31:0]);
         rd(rows[k][43:32], rows[k][31:0]);
      end
      wr(12'h204, 32'h1111_1111);
      wr(12'h204, 32'h0000_2200, 4'h2);
      rd(12'h204, 32'h1111_2211);
      // basic mode: 15 loses once, is retried, then 3
      wr(12'h230, 32'h0123_4567);
      wr(12'h2F0, 32'h0765_4321);
      wr(`OFS_DIRECTION, 32'h0);
      wr(`OFS_MBOX_ENABLE, 32'h0000_8008);
      fail <= 1'h1;
      wr(`OFS_TX_REQ_SET, 32'h0000_8008);
      for (i = 0; txf !== 1'h1 && i < 200; i++) @(negedge clk);
      @(posedge clk);
      fail <= 1'h0;
      wq(2);
      chk(fail_mb, 32'hF);
      chk(sent_q[0], 32'hF);
      chk(sent_q[1], 32'h3);
      // extended mode: level first, ties to the higher number, slow kernel
      wr(`OFS_MASTER_CTRL, 32'h0);
      wr(12'h234, 32'h0000_0708);
      wr(12'h2F4, 32'h0000_0208);
      wr(12'h2F8, 32'h5566_7788);
      wr(12'h2FC, 32'h99AA_BBCC);
      wr(12'h340, 32'h0111_1111);
      wr(12'h344, 32'h0000_0708);
      wr(`OFS_MBOX_ENABLE, 32'h0010_8008);
      sent_q.delete();
      lat <= 4'h5;
      wr(`OFS_TX_REQ_SET, 32'h0010_8008);
      wq(3);
      chk(sent_q[0], 32'h14);
      chk(sent_q[1], 32'h3);
      chk(sent_q[2], 32'hF);
      @(posedge clk);
      chk(cap_id, 32'h0765_4321);
      chk(cap_c, 32'h8);
      chk(cap_d[63:32], 32'h5566_7788);
      chk(cap_d[31:0], 32'h99AA_BBCC);
      // receive: 5 and 9 enabled, 12 receives but is disabled
      wr(`OFS_DIRECTION, 32'h0000_1220);
      wr(`OFS_MBOX_ENABLE, 32'h0000_0220);
      wr(12'h250, 32'h8000_0ABC);
      wr(12'h290, 32'h8000_0ABC);
      wr(12'h2C0, 32'h8000_0ABC);
      frame(29'h0ABC, 64'h0);
      chk(last_rx, 32'h9);
      frame(29'h0ABC, 64'h1234_5678_9ABC_DEF0);
      chk(last_rx, 32'h9);
      rd(`OFS_RX_LOST, 32'h200);
      rd(12'h298, 32'h1234_5678);
      wr(`OFS_OVR_PROTECT, 32'h200);
      frame(29'h0ABC, 64'h0);
      chk(last_rx, 32'h5);
      frame(29'h0777, 64'h0);
      chk(rx_cnt, 32'h3);
      rd(`OFS_RX_PENDING, 32'h220);
      wr(`OFS_RX_PENDING, 32'h220);
      rd(`OFS_RX_PENDING, 32'h0);
      // loop-back: no receiver configured, then mailbox 0 takes a frame
      wr(`OFS_MBOX_ENABLE, 32'h0);
      wr(`OFS_MASTER_CTRL, 32'h2);
      frame(29'h0777, 64'h0);
      chk(rx_cnt, 32'h4);
      chk(last_rx, 32'h5);
      wr(`OFS_MBOX_ENABLE, 32'h0000_0220);
      frame(29'h1ABC_DEF0, 64'h0);
      chk(last_rx, 32'h0);
      // compatible mode: shared mask of group 3-5, mailbox 20 out of range
      wr(`OFS_MASTER_CTRL, 32'h1);
      wr(12'h240, 32'hC000_0AB0);
      wr(12'h10C, 32'h0000_000F);
      wr(12'h340, 32'h8000_0AB7);
      wr(`OFS_DIRECTION, 32'h0010_0010);
      wr(`OFS_MBOX_ENABLE, 32'h0010_0010);
      // a frame offered while the clock enable is low is not seen
      ce <= 1'h0;
      frame(29'h0AB7, 64'h0);
      ce <= 1'h1;
      chk(rx_cnt, 32'h5);
      frame(29'h0AB7, 64'h0);
      chk(last_rx, 32'h4);
      chk(rx_cnt, 32'h6);
      chk(sent_cnt, 32'h5);
      // reset in mid-run brings the registers back
      rstn <= 1'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      rd(`OFS_MASTER_CTRL, `MC_RESET);
      rd(`OFS_RX_LOST, 32'h0);
      complete_run;
   end
endmodule
